// *** hdl/debug_req_pkg.sv ***
/*
  shared constants and carrier types for the external debug request handshake.
  assumes a single 100 MHz system clock and a synchronous active-low debug reset.
*/
package debug_req_pkg;
  localparam int          ADDR_W          = 32;
  localparam logic [3:0]  ENTRY_EXT_HALT  = 4'h4;
  localparam logic [3:0]  ENTRY_NONE      = 4'h0;
  localparam int          STAT_ENTRY_LSB  = 2;
  localparam int          STAT_ACK_FORCE  = 10;
  localparam int          STAT_TX_FULL    = 29;
  localparam int          STAT_RX_FULL    = 30;
  localparam logic [31:0] STAT_RESET      = 32'h0000_0000;
  localparam logic        LOW             = 1'b0;
  localparam logic        HIGH            = 1'b1;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_HALTING,
    ST_DEBUG
  } debug_state_t;

  // core-side events feeding the block
  typedef struct packed {
    logic halt_done;
    logic restart;
    logic barrier_complete;
    logic accesses_pending;
    logic rx_write;
    logic rx_read;
    logic tx_write;
    logic tx_read;
    logic ack_force_set;
    logic ack_force_clr;
  } core_events_t;
endpackage

// *** hdl/external_debug_request_handshake.sv ***
/*
  external debug request handshake: halt request, debug acknowledge, barrier done,
  channel status and static debug address outputs.
  assumes the halt request arrives from another clock domain; core events and the
  static address inputs come from logic on clk_sys.
*/
// Behaviour
// R1: halt request enters debug, entry code 0100
// R2: requester holds request until acknowledge
// R3: acknowledge asserted once in debug state
// R4: acknowledge forced high by force bit
// R5: barrier done after data sync barrier
// R6: barrier done waits for outstanding accesses
// R7: rx full output mirrors status bit 30
// R8: tx free output inverts status bit 29
// R9: present rom table base address
// R10: present self debug register offset
// R11: debug reset clears all debug outputs except tx free output, which resets high
// R12: acknowledge drops on leaving debug state
`timescale 1ns/1ps
module external_debug_request_handshake #(
  parameter int ADDR_W = debug_req_pkg::ADDR_W
) (
  input  wire logic                      clk_sys,
  input  wire logic                      resetn,
  input  wire logic                      halt_request_in,
  input  wire debug_req_pkg::core_events_t core_events,
  input  wire logic [ADDR_W-1:0]         rom_base_cfg,
  input  wire logic [ADDR_W-1:0]         self_offset_cfg,
  output logic                           debug_ack_out,
  output logic                           barrier_done_out,
  output logic                           rx_channel_full_out,
  output logic                           tx_channel_free_out,
  output logic [ADDR_W-1:0]              rom_table_base,
  output logic [ADDR_W-1:0]              self_debug_offset,
  output logic                           halt_event,
  output logic [31:0]                    debug_status_control_reg
);

  logic                        req_meta;
  logic                        req_sync;
  debug_req_pkg::debug_state_t state;
  debug_req_pkg::debug_state_t next_state;
  logic                        next_halt_event;
  logic                        enter_debug;
  logic [31:0]                 next_status;
  logic                        barrier_wait;
  logic                        next_barrier_wait;
  logic                        next_done;
  logic                        next_ack;
  logic                        next_rx_full;
  logic                        next_tx_free;
  logic [ADDR_W-1:0]           next_rom_base;
  logic [ADDR_W-1:0]           next_self_offset;

  // sticky status bit: a set in the same cycle as a clear wins, so an
  // event is never lost to a drain that raced it
  function automatic logic set_wins(
    input logic cur,
    input logic set,
    input logic clr
  );
    logic result;
    result = cur;
    if (clr) begin
      result = debug_req_pkg::LOW;
    end
    if (set) begin
      result = debug_req_pkg::HIGH;
    end
    return result;
  endfunction

  // two-stage synchroniser; only req_sync feeds logic
  // limitation: a release is seen two cycles late, so a restart sooner
  // than that after the release takes the stale request as a new one
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      req_meta <= debug_req_pkg::LOW;
      req_sync <= debug_req_pkg::LOW;
    end else begin
      req_meta <= halt_request_in;
      req_sync <= req_meta;
    end
  end

  // halt sequencing: run -> halting on a synchronised request,
  // halting -> debug once the core reports the halt, debug -> run on restart
  always_comb begin
    next_state      = state;
    next_halt_event = debug_req_pkg::LOW;
    enter_debug     = debug_req_pkg::LOW;
    case (state)
      debug_req_pkg::ST_RUN: begin
        // request only honoured while held; dropping it early is the requester's fault [R2]
        if (req_sync) begin
          next_halt_event = debug_req_pkg::HIGH; // [R1]
          next_state      = debug_req_pkg::ST_HALTING;
        end
      end
      debug_req_pkg::ST_HALTING: begin
        // entry method is latched on the same edge that raises acknowledge
        if (core_events.halt_done) begin
          enter_debug = debug_req_pkg::HIGH;     // [R1]
          next_state  = debug_req_pkg::ST_DEBUG; // [R1]
        end
      end
      debug_req_pkg::ST_DEBUG: begin
        if (core_events.restart) begin
          next_state = debug_req_pkg::ST_RUN; // [R12]
        end
      end
      default: begin
        next_state = debug_req_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin // [R11]
      state      <= debug_req_pkg::ST_RUN;
      halt_event <= debug_req_pkg::LOW;
    end else begin
      state      <= next_state;
      halt_event <= next_halt_event;
    end
  end

  // status word: entry method stays put after leaving debug,
  // so a debugger can still read why the core stopped
  always_comb begin
    next_status = debug_status_control_reg;
    if (enter_debug) begin
      next_status[debug_req_pkg::STAT_ENTRY_LSB +: $bits(debug_req_pkg::ENTRY_EXT_HALT)]
        = debug_req_pkg::ENTRY_EXT_HALT; // [R1]
    end
    next_status[debug_req_pkg::STAT_ACK_FORCE] = set_wins( // [R4]
      debug_status_control_reg[debug_req_pkg::STAT_ACK_FORCE],
      core_events.ack_force_set,
      core_events.ack_force_clr
    );
    next_status[debug_req_pkg::STAT_RX_FULL] = set_wins( // [R7]
      debug_status_control_reg[debug_req_pkg::STAT_RX_FULL],
      core_events.rx_write,
      core_events.rx_read
    );
    next_status[debug_req_pkg::STAT_TX_FULL] = set_wins( // [R8]
      debug_status_control_reg[debug_req_pkg::STAT_TX_FULL],
      core_events.tx_write,
      core_events.tx_read
    );
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin // [R11]
      debug_status_control_reg <= debug_req_pkg::STAT_RESET;
    end else begin
      debug_status_control_reg <= next_status;
    end
  end

  // done is held off until the barrier retires and no accesses remain [R5] [R6]
  always_comb begin
    next_barrier_wait = barrier_wait;
    next_done         = barrier_done_out;
    if (core_events.barrier_complete) begin
      next_barrier_wait = debug_req_pkg::HIGH;
      next_done         = debug_req_pkg::LOW;
    end
    if (next_barrier_wait && !core_events.accesses_pending) begin
      next_done         = debug_req_pkg::HIGH; // [R5] [R6]
      next_barrier_wait = debug_req_pkg::LOW;
    end
    // an access still in flight always wins, whatever the barrier did
    if (core_events.accesses_pending) begin
      next_done = debug_req_pkg::LOW; // [R6]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin // [R11]
      barrier_wait     <= debug_req_pkg::LOW;
      barrier_done_out <= debug_req_pkg::LOW;
    end else begin
      barrier_wait     <= next_barrier_wait;
      barrier_done_out <= next_done;
    end
  end

  // static address copies: one cycle of lag, harmless for values fixed at build
  always_comb begin
    next_rom_base    = rom_base_cfg;    // [R9]
    next_self_offset = self_offset_cfg; // [R10]
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin // [R11]
      rom_table_base    <= '0;
      self_debug_offset <= '0;
    end else begin
      rom_table_base    <= next_rom_base;
      self_debug_offset <= next_self_offset;
    end
  end

  // acknowledge follows the next state so it rises on the entry edge itself;
  // channel outputs follow the next status so they never lag the status word
  always_comb begin
    next_ack     = (next_state == debug_req_pkg::ST_DEBUG) // [R3] [R12]
                || next_status[debug_req_pkg::STAT_ACK_FORCE]; // [R4]
    next_rx_full = next_status[debug_req_pkg::STAT_RX_FULL];  // [R7]
    next_tx_free = !next_status[debug_req_pkg::STAT_TX_FULL]; // [R8]
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin // [R11]
      debug_ack_out       <= debug_req_pkg::LOW;
      rx_channel_full_out <= debug_req_pkg::LOW;
      tx_channel_free_out <= debug_req_pkg::HIGH;
    end else begin
      debug_ack_out       <= next_ack;
      rx_channel_full_out <= next_rx_full;
      tx_channel_free_out <= next_tx_free;
    end
  end

endmodule

// *** verification/debug_agent_model.sv ***
/*
  halting agent: raises the halt request on go and holds it until acknowledge.
  assumes go is a one-cycle pulse on clk_sys; resetn parks the request low.
*/
`timescale 1ns/1ps
module debug_agent_model (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic go,
  input  wire logic debug_ack_out,
  output logic      halt_request_in
);
  // early release leaves the core unpredictable, so drop only after ack
  always @(posedge clk_sys) begin
    if (!resetn) begin
      halt_request_in <= #1 1'b0;
    end else if (go) begin
      halt_request_in <= #1 1'b1;
    end else if (debug_ack_out) begin
      halt_request_in <= #1 1'b0;
    end
  end
endmodule

// *** verification/debug_req_checker.sv ***
/*
  port assertions for the debug request handshake.
  assumes one clock and the synchronous debug reset.
*/
`timescale 1ns/1ps
module debug_req_checker (
  input wire logic                         clk_sys,
  input wire logic                         resetn,
  input wire debug_req_pkg::core_events_t  core_events,
  input wire logic                         debug_ack_out,
  input wire logic                         barrier_done_out,
  input wire logic                         rx_channel_full_out,
  input wire logic                         tx_channel_free_out,
  input wire logic                         halt_event,
  input wire logic [31:0]                  debug_status_control_reg,
  input wire logic [31:0]                  rom_base_cfg,
  input wire logic [31:0]                  rom_table_base
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  entry_code_a: assert property ($rose(debug_ack_out) && !debug_status_control_reg[10]
    |-> debug_status_control_reg[5:2] == 4'h4) else $error("entry code wrong");
  // a halt is in progress from the accepted request until acknowledge
  logic halting;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      halting <= 1'b0;
    end else if (halt_event) begin
      halting <= 1'b1;
    end else if (debug_ack_out) begin
      halting <= 1'b0;
    end
  end
  halt_ack_a: assert property (halting && core_events.halt_done |=> debug_ack_out)
    else $error("ack missing");
  force_ack_a: assert property ($past(debug_status_control_reg[10])
    && debug_status_control_reg[10] |-> debug_ack_out) else $error("force ignored");
  done_rise_a: assert property (core_events.barrier_complete &&
    !core_events.accesses_pending |=> barrier_done_out) else $error("done missing");
  done_wait_a: assert property (core_events.accesses_pending |=> !barrier_done_out)
    else $error("done early");
  rx_mirror_a: assert property (rx_channel_full_out == debug_status_control_reg[30])
    else $error("rx flag wrong");
  tx_inverse_a: assert property (tx_channel_free_out != debug_status_control_reg[29])
    else $error("tx flag wrong");
  rom_copy_a: assert property ($past(resetn) |-> rom_table_base == $past(rom_base_cfg))
    else $error("rom base wrong");
  ack_drop_a: assert property (core_events.restart && debug_ack_out &&
    !debug_status_control_reg[10] && !core_events.ack_force_set
    |=> !debug_ack_out) else $error("ack stuck");
  cover property (halt_event);
  cover property ($rose(barrier_done_out));
  cover property ($rose(rx_channel_full_out));
endmodule
bind external_debug_request_handshake debug_req_checker debug_req_checker_i (.*);

// *** verification/external_debug_request_handshake_tb.sv ***
/*
  directed bench for the debug request handshake.
  assumes core event bit order of the package struct, msb halt_done.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
  $display("unexpected %0t %h %h", $time, a, b); end end
module external_debug_request_handshake_tb;
  logic clk_sys, resetn, go, debug_ack_out, barrier_done_out, halt_request_in;
  logic rx_channel_full_out, tx_channel_free_out, halt_event;
  logic [31:0] rom_base_cfg, self_offset_cfg, rom_table_base, self_debug_offset;
  logic [31:0] debug_status_control_reg;
  debug_req_pkg::core_events_t core_events;
  int errors, checked;
  external_debug_request_handshake external_debug_request_handshake_i (
    .clk_sys                  (clk_sys),
    .resetn                   (resetn),
    .halt_request_in          (halt_request_in),
    .core_events              (core_events),
    .rom_base_cfg             (rom_base_cfg),
    .self_offset_cfg          (self_offset_cfg),
    .debug_ack_out            (debug_ack_out),
    .barrier_done_out         (barrier_done_out),
    .rx_channel_full_out      (rx_channel_full_out),
    .tx_channel_free_out      (tx_channel_free_out),
    .rom_table_base           (rom_table_base),
    .self_debug_offset        (self_debug_offset),
    .halt_event               (halt_event),
    .debug_status_control_reg (debug_status_control_reg)
  );
  debug_agent_model debug_agent_model_i (
    .clk_sys         (clk_sys),
    .resetn          (resetn),
    .go              (go),
    .debug_ack_out   (debug_ack_out),
    .halt_request_in (halt_request_in)
  );
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // one-cycle core event pulse by struct bit index
  task ev(input int b);
    tick(1);
    core_events[b] = 1'b1;
    tick(1);
    core_events[b] = 1'b0;
  endtask
  task results;
    if (errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    resetn          = 1'b0;
    go              = 1'b0;
    core_events     = '0;
    rom_base_cfg    = 32'h8000_0000;
    self_offset_cfg = 32'h0001_0000;
    tick(5);
    `CHK(tx_channel_free_out, 1'b1)
    resetn = 1'b1;
    tick(3);
    `CHK(rom_table_base, 32'h8000_0000)
    `CHK(self_debug_offset, 32'h0001_0000)
    go = 1'b1;
    tick(1);
    go = 1'b0;
    // pin, two synchroniser stages, then the accepting edge
    tick(3);
    `CHK(halt_event, 1'b1)
    tick(1);
    `CHK(halt_event, 1'b0)
    `CHK(debug_ack_out, 1'b0)
    ev(9);
    `CHK(debug_ack_out, 1'b1)
    `CHK(debug_status_control_reg[5:2], 4'h4)
    // let the released request drain through the synchroniser before restart
    tick(2);
    ev(8);
    `CHK(debug_ack_out, 1'b0)
    ev(1);
    tick(2);
    `CHK(debug_ack_out, 1'b1)
    ev(0);
    tick(2);
    `CHK(debug_ack_out, 1'b0)
    core_events[6] = 1'b1;
    ev(7);
    `CHK(barrier_done_out, 1'b0)
    core_events[6] = 1'b0;
    tick(2);
    `CHK(barrier_done_out, 1'b1)
    core_events[6] = 1'b1;
    tick(1);
    core_events[6] = 1'b0;
    `CHK(barrier_done_out, 1'b0)
    ev(7);
    `CHK(barrier_done_out, 1'b1)
    ev(5);
    tick(1);
    `CHK(rx_channel_full_out, 1'b1)
    ev(4);
    tick(1);
    `CHK(rx_channel_full_out, 1'b0)
    ev(3);
    tick(1);
    `CHK(tx_channel_free_out, 1'b0)
    ev(2);
    tick(1);
    `CHK(tx_channel_free_out, 1'b1)
    ev(5);
    ev(1);
    ev(3);
    tick(2);
    resetn = 1'b0;
    tick(2);
    `CHK({debug_ack_out, barrier_done_out, rx_channel_full_out}, 3'h0)
    `CHK(tx_channel_free_out, 1'b1)
    `CHK(debug_status_control_reg, 32'h0000_0000)
    resetn = 1'b1;
    tick(2);
    `CHK(debug_ack_out, 1'b0)
    results;
  end
  // whole run is under 100 cycles
  initial begin
    repeat (2000) @(posedge clk_sys);
    errors++;
    results;
  end
endmodule
